// [hw/contact_pkg.sv]
// contact input conditioning: shared constants, register map and carriers.
// assumes a 25 MHz system clock and a single synchronous reset.
package contact_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCAN_PERIOD_NS = 250_000;
  localparam int SCAN_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int SCANS_PER_SEC = SECOND_NS / SCAN_PERIOD_NS;

  // debounce time in quarter milliseconds (scan periods)
  localparam logic [6:0] DEB_MIN = 7'h06;
  localparam logic [6:0] DEB_MAX = 7'h40;
  localparam logic [6:0] DEB_RST = 7'h08;

  // chatter window in seconds and state-change limit
  localparam logic [6:0] WIN_MIN = 7'h01;
  localparam logic [6:0] WIN_MAX = 7'h64;
  localparam logic [6:0] WIN_RST = 7'h0a;
  localparam logic [6:0] LIM_MIN = 7'h0a;
  localparam logic [6:0] LIM_MAX = 7'h64;
  localparam logic [6:0] LIM_RST = 7'h1e;
  localparam logic CHAT_EN_RST = 1'b0;
  localparam logic EVT_EN_RST = 1'b0;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAT_TIME = 8'h04;
  localparam logic [7:0] OFS_CHAT_LIMIT = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_TROUBLE = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_EVT_EN = 8'h1c;
  localparam logic [7:0] OFS_DEB_BASE = 8'h40;
  localparam int CTRL_CHAT_EN_BIT = 0;

  // per-input working state, kept in the state memory
  typedef struct packed {
    logic stable;
    logic cand;
    logic [6:0] deb_cnt;
    logic [31:0] stamp;
    logic [6:0] chat_cnt;
    logic [6:0] win_cnt;
    logic [7:0] quiet_cnt;
    logic trouble;
  } in_state_s;

  // event record towards the recorder
  typedef struct packed {
    logic [5:0] idx;
    logic state;
    logic [31:0] stamp;
  } evt_s;

endpackage : contact_pkg

// [hw/contact_state_mem.sv]
// small state memory: one word per contact input, registered read data.
// assumes one read and one write per cycle; reset clears every word.
module contact_state_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data,
  // write port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= '0;
      end
    end else if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule : contact_state_mem

// [hw/contact_input_debounce_chatter.sv]
// contact input debounce, event time-stamping and chatter supervision.
// assumes raw comparator outputs asynchronous to i_clk_sys, an avalon-mm
// master for settings and a recorder that takes one event per pulse.
// Contract
// - All raw inputs are sampled together on one scan tick every 0.25 ms.
// - A new state is accepted only after it held for the debounce time.
// - The same debounce time and method serve rising and falling changes.
// - A logged change carries the time of its first new-state sample.
// - Debounce time is 1.5 to 16.0 ms in 0.25 ms steps, default 2.0 ms.
// - With its event enable set, each validated change makes an event.
// - Changes within the chatter window above the limit set trouble.
// - An input in trouble has its operand blocked and reports muted.
// - Trouble clears after no changes for twice the chatter window.
// - Chatter window is 1 to 100 s in 1 s steps, default 10 s.
// - Chatter limit is 10 to 100 in steps of one, default 30.
// - Chatter detection works only when enabled, default disabled.
module contact_input_debounce_chatter #(
  parameter int NUM_INPUTS = 8,
  parameter int SCAN_CYCLES = contact_pkg::SCAN_CYCLES,
  parameter int SCANS_PER_SEC = contact_pkg::SCANS_PER_SEC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // raw contact comparators
  input wire logic [NUM_INPUTS-1:0] i_raw,
  // logic operands and trouble flags
  output logic [NUM_INPUTS-1:0] o_operand,
  output logic [NUM_INPUTS-1:0] o_trouble,
  // event recorder
  output logic o_evt_valid,
  output contact_pkg::evt_s o_evt,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // interrupt
  output logic o_irq
);

  localparam int IW = (NUM_INPUTS > 1) ? $clog2(NUM_INPUTS) : 1;
  localparam int SW = $bits(contact_pkg::in_state_s);

  function automatic logic [6:0] clamp7(input logic [31:0] v,
                                        input logic [6:0] lo,
                                        input logic [6:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return v[6:0];
  endfunction : clamp7

  // settings
  logic chat_en;
  logic [6:0] chat_time;
  logic [6:0] chat_limit;
  logic [NUM_INPUTS-1:0] evt_en;
  logic [NUM_INPUTS-1:0] irq_status;
  logic [NUM_INPUTS-1:0] irq_mask;
  logic [6:0] deb_time [NUM_INPUTS];
  logic [NUM_INPUTS-1:0] stable_q;

  // bus handshake
  logic bus_req;
  logic bus_acc;
  logic [31:0] next_rdata;
  logic [5:0] word;
  logic [IW-1:0] deb_sel;
  logic deb_hit;

  // scan timing
  logic [NUM_INPUTS-1:0] raw_meta;
  logic [NUM_INPUTS-1:0] raw_sync;
  logic [NUM_INPUTS-1:0] snap;
  logic [31:0] scan_div;
  logic [31:0] sec_div;
  logic scan_tick;
  logic sec_hit;
  logic sweep_sec;
  logic [31:0] ts;

  // sweep over inputs
  logic sweeping;
  logic [IW-1:0] rd_idx;
  logic p_valid;
  logic [IW-1:0] p_idx;
  logic [SW-1:0] rd_data;
  contact_pkg::in_state_s cur;
  contact_pkg::in_state_s nxt;
  logic changed;
  logic evt_fire;
  logic [NUM_INPUTS-1:0] evt_set;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      raw_meta <= '0;
      raw_sync <= '0;
    end else begin
      raw_meta <= i_raw;
      raw_sync <= raw_meta;
    end
  end

  // scan tick divider, one-second divider counted in scan ticks
  assign scan_tick = (scan_div == 32'(SCAN_CYCLES - 1));
  assign sec_hit = (sec_div == 32'(SCANS_PER_SEC - 1));

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scan_div <= '0;
      sec_div <= '0;
      ts <= '0;
      snap <= '0;
      sweep_sec <= 1'b0;
    end else if (scan_tick) begin
      scan_div <= '0;
      sec_div <= sec_hit ? 32'h0000_0000 : sec_div + 32'h0000_0001;
      ts <= ts + 32'h0000_0001;
      snap <= raw_sync;
      sweep_sec <= sec_hit;
    end else begin
      scan_div <= scan_div + 32'h0000_0001;
    end
  end

  // one input per cycle after each tick; the sweep ends long before the next
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sweeping <= 1'b0;
      rd_idx <= '0;
      p_valid <= 1'b0;
      p_idx <= '0;
    end else begin
      p_valid <= sweeping;
      p_idx <= rd_idx;
      if (scan_tick) begin
        sweeping <= 1'b1;
        rd_idx <= '0;
      end else if (sweeping) begin
        if (rd_idx == IW'(NUM_INPUTS - 1)) begin
          sweeping <= 1'b0;
        end else begin
          rd_idx <= rd_idx + IW'(1);
        end
      end
    end
  end

  contact_state_mem #(
    .WIDTH(SW),
    .DEPTH(NUM_INPUTS),
    .AW(IW)
  ) u_state (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_rd_addr(rd_idx),
    .o_rd_data(rd_data),
    .i_wr_en(p_valid),
    .i_wr_addr(p_idx),
    .i_wr_data(SW'(nxt))
  );

  // debounce and chatter update of the input under the sweep
  always_comb begin
    cur = contact_pkg::in_state_s'(rd_data);
    nxt = cur;
    changed = 1'b0;
    if (snap[p_idx] == cur.stable) begin
      nxt.cand = cur.stable;
      nxt.deb_cnt = 7'h00;
    end else if (snap[p_idx] != cur.cand || cur.deb_cnt == 7'h00) begin
      nxt.cand = snap[p_idx];
      nxt.deb_cnt = 7'h01;
      nxt.stamp = ts;
    end else begin
      nxt.deb_cnt = cur.deb_cnt + 7'h01;
    end
    // symmetric: no polarity in the test
    if (snap[p_idx] != cur.stable && nxt.deb_cnt >= deb_time[p_idx]) begin
      nxt.stable = snap[p_idx];
      nxt.deb_cnt = 7'h00;
      changed = 1'b1;
    end
    if (changed) begin
      if (cur.chat_cnt == 7'h00) begin
        nxt.win_cnt = 7'h00;
      end
      if (cur.chat_cnt != 7'h7f) begin
        nxt.chat_cnt = cur.chat_cnt + 7'h01;
      end
      nxt.quiet_cnt = 8'h00;
    end else if (sweep_sec) begin
      if (cur.chat_cnt != 7'h00) begin
        if (cur.win_cnt + 7'h01 >= chat_time) begin
          nxt.chat_cnt = 7'h00;
          nxt.win_cnt = 7'h00;
        end else begin
          nxt.win_cnt = cur.win_cnt + 7'h01;
        end
      end
      if (cur.trouble) begin
        if (cur.quiet_cnt + 8'h01 >= {chat_time, 1'b0}) begin
          nxt.trouble = 1'b0;
          nxt.quiet_cnt = 8'h00;
          nxt.chat_cnt = 7'h00;
          nxt.win_cnt = 7'h00;
        end else begin
          nxt.quiet_cnt = cur.quiet_cnt + 8'h01;
        end
      end
    end
    // idle while off: nothing counted, so enabling starts from a clean slate
    if (!chat_en) begin
      nxt.chat_cnt = 7'h00;
      nxt.win_cnt = 7'h00;
      nxt.quiet_cnt = 8'h00;
      nxt.trouble = 1'b0;
    end else if (nxt.chat_cnt > chat_limit) begin
      nxt.trouble = 1'b1;
    end
    // reports muted while in trouble
    evt_fire = changed && evt_en[p_idx] && !nxt.trouble;
    evt_set = (p_valid && evt_fire) ? (NUM_INPUTS'(1) << p_idx) : '0;
  end

  // operands and flags
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stable_q <= '0;
      o_trouble <= '0;
      o_operand <= '0;
    end else if (p_valid) begin
      stable_q[p_idx] <= nxt.stable;
      o_trouble[p_idx] <= nxt.trouble;
      o_operand[p_idx] <= nxt.stable & ~nxt.trouble;
    end
  end

  // event record; the sweep serialises simultaneous changes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_evt_valid <= 1'b0;
      o_evt <= '0;
    end else begin
      o_evt_valid <= p_valid && evt_fire;
      if (p_valid && evt_fire) begin
        o_evt <= '{idx: 6'(p_idx), state: nxt.stable, stamp: nxt.stamp};
      end
    end
  end

  // avalon-mm: waitrequest drops one cycle after the request appears
  assign bus_req = i_avs_read | i_avs_write;
  assign bus_acc = bus_req & ~o_avs_waitrequest;
  assign word = i_avs_address[7:2];
  assign deb_hit = (i_avs_address[7:6] == contact_pkg::OFS_DEB_BASE[7:6])
                   && (32'(i_avs_address[5:2]) < 32'(NUM_INPUTS));
  assign deb_sel = IW'(i_avs_address[5:2]);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (deb_hit) begin
      next_rdata = 32'(deb_time[deb_sel]);
    end else begin
      unique case (word)
        contact_pkg::OFS_CTRL[7:2]:
          next_rdata[contact_pkg::CTRL_CHAT_EN_BIT] = chat_en;
        contact_pkg::OFS_CHAT_TIME[7:2]:
          next_rdata = 32'(chat_time);
        contact_pkg::OFS_CHAT_LIMIT[7:2]:
          next_rdata = 32'(chat_limit);
        contact_pkg::OFS_STATE[7:2]: next_rdata = 32'(stable_q);
        contact_pkg::OFS_TROUBLE[7:2]: next_rdata = 32'(o_trouble);
        contact_pkg::OFS_IRQ_STATUS[7:2]: next_rdata = 32'(irq_status);
        contact_pkg::OFS_IRQ_MASK[7:2]: next_rdata = 32'(irq_mask);
        contact_pkg::OFS_EVT_EN[7:2]: next_rdata = 32'(evt_en);
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_avs_readdata <= '0;
    end else if (bus_req && o_avs_waitrequest && i_avs_read) begin
      o_avs_readdata <= next_rdata;
    end
  end

  // settings writes, clamped to their legal ranges
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      chat_en <= contact_pkg::CHAT_EN_RST;
      chat_time <= contact_pkg::WIN_RST;
      chat_limit <= contact_pkg::LIM_RST;
      evt_en <= {NUM_INPUTS{contact_pkg::EVT_EN_RST}};
      irq_mask <= '0;
      for (int k = 0; k < NUM_INPUTS; k++) begin
        deb_time[k] <= contact_pkg::DEB_RST;
      end
    end else if (bus_acc && i_avs_write) begin
      if (deb_hit) begin
        deb_time[deb_sel] <= clamp7(i_avs_writedata, contact_pkg::DEB_MIN,
                                    contact_pkg::DEB_MAX);
      end else begin
        unique case (word)
          contact_pkg::OFS_CTRL[7:2]:
            chat_en <= i_avs_writedata[contact_pkg::CTRL_CHAT_EN_BIT];
          contact_pkg::OFS_CHAT_TIME[7:2]:
            chat_time <= clamp7(i_avs_writedata, contact_pkg::WIN_MIN,
                                contact_pkg::WIN_MAX);
          contact_pkg::OFS_CHAT_LIMIT[7:2]:
            chat_limit <= clamp7(i_avs_writedata, contact_pkg::LIM_MIN,
                                 contact_pkg::LIM_MAX);
          contact_pkg::OFS_IRQ_MASK[7:2]:
            irq_mask <= i_avs_writedata[NUM_INPUTS-1:0];
          contact_pkg::OFS_EVT_EN[7:2]:
            evt_en <= i_avs_writedata[NUM_INPUTS-1:0];
          default: ;
        endcase
      end
    end
  end

  // sticky event status; a read clears only the bits it reported, so an
  // event landing between capture and acceptance is not lost
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq_status <= '0;
      o_irq <= 1'b0;
    end else begin
      if (bus_acc && i_avs_read && !deb_hit
          && word == contact_pkg::OFS_IRQ_STATUS[7:2]) begin
        irq_status <= (irq_status & ~o_avs_readdata[NUM_INPUTS-1:0])
                      | evt_set;
      end else begin
        irq_status <= irq_status | evt_set;
      end
      o_irq <= |(irq_status & irq_mask);
    end
  end

endmodule : contact_input_debounce_chatter

// [verif/contact_chk_monitor.sv]
// checker: port-level properties of the contact conditioning block.
// assumes settings reach the block only through taken avalon writes.
module contact_chk_monitor #(
  parameter int NUM_INPUTS = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // contact side
  input wire logic [NUM_INPUTS-1:0] o_operand,
  input wire logic [NUM_INPUTS-1:0] o_trouble,
  input wire logic o_evt_valid,
  input wire contact_pkg::evt_s o_evt,
  // register bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic o_irq
);
  logic chat_en;
  logic [NUM_INPUTS-1:0] evt_en;
  logic [NUM_INPUTS-1:0] mask;
  logic [7:0] wa;
  assign wa = {i_avs_address[7:2], 2'b00};
  // shadow copies, updated at the same edge the block takes the write
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      chat_en <= 1'b0;
      evt_en <= '0;
      mask <= '0;
    end else if (i_avs_write && !o_avs_waitrequest) begin
      if (wa == contact_pkg::OFS_CTRL) chat_en <= i_avs_writedata[0];
      if (wa == contact_pkg::OFS_EVT_EN)
        evt_en <= i_avs_writedata[NUM_INPUTS-1:0];
      if (wa == contact_pkg::OFS_IRQ_MASK)
        mask <= i_avs_writedata[NUM_INPUTS-1:0];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  AST_BUS_ANSWER: assert property ((i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle wide");
  AST_BLOCKED: assert property ((o_operand & o_trouble) == '0)
    else $error("operand high while in trouble");
  AST_EVT_MUTED: assert property (o_evt_valid
    |-> !o_trouble[o_evt.idx])
    else $error("event from input in trouble");
  AST_EVT_ENABLED: assert property (o_evt_valid
    |-> evt_en[o_evt.idx])
    else $error("event from disabled input");
  AST_EVT_STATE: assert property (o_evt_valid
    |-> o_operand[o_evt.idx] == o_evt.state)
    else $error("event state differs from operand");
  AST_DEB_HOLD: assert property ($changed(o_operand[0])
    && $stable(o_trouble[0]) |=> $stable(o_operand[0])[*8])
    else $error("operand changed twice too fast");
  AST_RST_CLEAR: assert property ($fell(i_reset)
    |-> o_trouble == '0 && o_operand == '0)
    else $error("state not cleared by reset");
  AST_IRQ_MASK: assert property (o_irq |-> $past(mask) != '0)
    else $error("interrupt with all sources masked");
  AST_CHAT_OFF: assert property ($rose(o_trouble[0])
    |-> $past(chat_en))
    else $error("trouble while chatter detection off");
  COV_EVT: cover property (o_evt_valid);
  COV_TROUBLE: cover property ($rose(o_trouble[0]));
  COV_CLEAR: cover property ($fell(o_trouble[0]));
endmodule : contact_chk_monitor

bind contact_input_debounce_chatter contact_chk_monitor #(
  .NUM_INPUTS(NUM_INPUTS)) u_mon (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .o_operand(o_operand),
  .o_trouble(o_trouble), .o_evt_valid(o_evt_valid), .o_evt(o_evt),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq));

// [verif/contact_field_model.sv]
// field contact model: comparator outputs seen by the block.
// assumes the bench commands contact state and bounce per input.
module contact_field_model #(
  parameter int NUM_INPUTS = 2,
  parameter int DELAY = 3,
  parameter int BOUNCE_CYC = 13
) (
  // clock
  input wire logic i_clk_sys,
  // commanded contact
  input wire logic [NUM_INPUTS-1:0] i_closed,
  input wire logic [NUM_INPUTS-1:0] i_bounce,
  // comparator outputs
  output logic [NUM_INPUTS-1:0] o_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [NUM_INPUTS-1:0] dly [DELAY] = '{default: '0};
  int ph = 0;
  logic flip = 1'b0;
  // slow comparator: settles DELAY clocks after the contact moves
  always_ff @(posedge i_clk_sys) begin
    ph <= (ph == BOUNCE_CYC - 1) ? 0 : ph + 1;
    if (ph == BOUNCE_CYC - 1) flip <= !flip;
    dly[0] <= i_closed;
    for (int k = 1; k < DELAY; k++) dly[k] <= dly[k-1];
  end
  // bounce period not a divisor of the scan, so samples never settle
  assign o_raw = dly[DELAY-1] ^ (i_bounce & {NUM_INPUTS{flip}});
endmodule : contact_field_model

// [verif/testbench.sv]
// bench: settings over avalon-mm, contacts through the field model.
// assumes short scan and second counts so the run stays brief.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 2;
  localparam int SC = 20;
  localparam int SEC = SC * 4;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [N-1:0] closed = '0;
  logic [N-1:0] bounce = '0;
  logic [N-1:0] raw;
  logic [N-1:0] operand;
  logic [N-1:0] trouble;
  logic evt_valid;
  contact_pkg::evt_s evt;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic waitreq;
  logic irq;
  logic [31:0] q;
  int cyc = 0;
  int error_cnt = 0;
  int n_tests = 0;
  int evt_cnt = 0;
  int n0;
  logic [7:0] ca [6] = '{8'h40, 8'h40, 8'h04, 8'h04, 8'h08, 8'h08};
  logic [31:0] cw [6] = '{32'h41, 32'h05, 32'h00, 32'h65, 32'h09, 32'h65};
  logic [31:0] cr [6] = '{32'h40, 32'h06, 32'h01, 32'h64, 32'h0a, 32'h64};
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= i_reset ? 0 : cyc + 1;
    if (evt_valid === 1'b1) evt_cnt <= evt_cnt + 1;
  end
  contact_field_model #(.NUM_INPUTS(N)) u_field (.i_clk_sys(i_clk_sys),
    .i_closed(closed), .i_bounce(bounce), .o_raw(raw));
  contact_input_debounce_chatter #(.NUM_INPUTS(N), .SCAN_CYCLES(SC),
    .SCANS_PER_SEC(4)) dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_raw(raw), .o_operand(operand), .o_trouble(trouble),
    .o_evt_valid(evt_valid), .o_evt(evt), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq));
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge i_clk_sys);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50) check("bus_timeout", 1, 0);
  endtask : bus
  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(name, q, exp);
  endtask : rchk
  task automatic deb_pass(input logic v);
    int s;
    int k = 0;
    bounce <= 2'b01;
    repeat (100) @(posedge i_clk_sys);
    bounce <= 2'b00;
    repeat (40) @(posedge i_clk_sys);
    do @(posedge i_clk_sys); while (cyc % SC != 5);
    closed <= {N{v}};
    s = cyc / SC + 1;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (evt_valid !== 1'b1 && k < 400);
    check("evt_idx", evt.idx, 0);
    check("evt_state", evt.state, v);
    check("evt_stamp", evt.stamp, s);
    check("evt_time", cyc / SC, s + 5);
    repeat (2) @(posedge i_clk_sys);
    check("irq_set", irq, 1);
    rchk("irq_status", contact_pkg::OFS_IRQ_STATUS, 1);
    rchk("irq_clear", contact_pkg::OFS_IRQ_STATUS, 0);
    repeat (3 * SC) @(posedge i_clk_sys);
    check("irq_low", irq, 0);
    rchk("state", contact_pkg::OFS_STATE, {N{v}});
  endtask : deb_pass
  task automatic toggle(input int n);
    repeat (n) begin
      closed[0] <= !closed[0];
      repeat (7 * SC) @(posedge i_clk_sys);
    end
  endtask : toggle
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rchk("ctrl", contact_pkg::OFS_CTRL, 32'h0000_0000);
    rchk("win", contact_pkg::OFS_CHAT_TIME, 32'h0000_000a);
    rchk("limit", contact_pkg::OFS_CHAT_LIMIT, 32'h0000_001e);
    rchk("evt_en", contact_pkg::OFS_EVT_EN, 32'h0000_0000);
    rchk("deb1", 8'h44, 32'h0000_0008);
    rchk("unmapped", 8'h3c, 32'h0000_0000);
    foreach (ca[j]) begin
      bus(1'b1, ca[j], cw[j]);
      rchk("clamp", ca[j], cr[j]);
    end
    $display("test settings done");
    bus(1'b1, contact_pkg::OFS_EVT_EN, 32'h0000_0001);
    bus(1'b1, contact_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    rchk("mask", contact_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    bus(1'b1, contact_pkg::OFS_CHAT_TIME, 32'h0000_001e);
    bus(1'b1, contact_pkg::OFS_CHAT_LIMIT, 32'h0000_000a);
    deb_pass(1'b1);
    deb_pass(1'b0);
    $display("test debounce done");
    toggle(12);
    check("trouble_off", trouble, 0);
    bus(1'b1, contact_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (32 * SEC) @(posedge i_clk_sys);
    n0 = evt_cnt;
    toggle(10);
    check("trouble_10", trouble, 0);
    toggle(1);
    check("trouble_11", trouble, 2'b01);
    check("blocked", operand, 0);
    rchk("trbl_reg", contact_pkg::OFS_TROUBLE, 32'h0000_0001);
    rchk("state_raw", contact_pkg::OFS_STATE, 32'h0000_0001);
    toggle(2);
    check("evt_muted", evt_cnt - n0, 10);
    repeat (57 * SEC) @(posedge i_clk_sys);
    check("quiet_early", trouble, 2'b01);
    repeat (6 * SEC) @(posedge i_clk_sys);
    check("quiet_clear", trouble, 0);
    check("operand_back", operand, 2'b01);
    $display("test chatter done");
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    check("rst_operand", operand, 0);
    rchk("rst_ctrl", contact_pkg::OFS_CTRL, 32'h0000_0000);
    $display("test reset done");
    test_done();
  end
endmodule : testbench
